//--- verilog/aisd_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Core clock at 250 MHz
// Notes:   Offsets are byte offsets on the plain register port
`ifndef AISD_REGS_SVH
`define AISD_REGS_SVH

`define AISD_ADDR_W            8
`define AISD_OFF_CELL_INTERVAL 8'h3e
`define AISD_OFF_AUX_INTERVAL  8'h3f
`define AISD_OFF_TEST_INTERVAL 8'h43
`define AISD_OFF_SHDN_STATUS   8'h50
`define AISD_OFF_IRQ_STATUS    8'h60
`define AISD_OFF_IRQ_MASK      8'h61

`define AISD_RST_CELL_INTERVAL 8'h00
`define AISD_RST_AUX_INTERVAL  32'h00000000
`define AISD_RST_TEST_INTERVAL 16'h0900
`define AISD_RST_SHDN_STATUS   8'h00

`define AISD_BIT_CTRL_PD       7
`define AISD_BIT_DIG_TSD       6
`define AISD_BIT_AO_LOSS       5
`define AISD_BIT_ANALOG_REQ    4
`define AISD_BIT_REG_SLOW      1
`define AISD_BIT_ANALOG_TSD    0
`define AISD_SHDN_RW_MASK      8'hf3

// Sampling cycles per interval code at 250 MHz, rounded down
`define AISD_CYC_CODE_0        18'd1032
`define AISD_CYC_CODE_1        18'd1490
`define AISD_CYC_CODE_2        18'd2005
`define AISD_CYC_CODE_3        18'd2500
`define AISD_CYC_CODE_4        18'd3150
`define AISD_CYC_CODE_5        18'd3725
`define AISD_CYC_CODE_6        18'd4350
`define AISD_CYC_CODE_7        18'd4975
`define AISD_CYC_CODE_8        18'd6225
`define AISD_CYC_CODE_9        18'd7500
`define AISD_CYC_CODE_A        18'd10025
`define AISD_CYC_CODE_B        18'd15000
`define AISD_CYC_CODE_C        18'd25000
`define AISD_CYC_CODE_D        18'd50000
`define AISD_CYC_CODE_E        18'd125000
`define AISD_CYC_CODE_F        18'd250000

`define AISD_CLK_MHZ           250
`define AISD_CYC_W             18

`endif

//--- verilog/aisd_pkg.sv
// Purpose: Types shared by the interval and shutdown status block
// Assumes: Codes are four bits wide
// Notes:   Constants live in aisd_regs.svh
package aisd_pkg;
    typedef logic [3:0]  aisd_code_t;
    typedef logic [17:0] aisd_cycles_t;
    typedef enum logic [1:0]
    {
        AISD_IDLE = 2'b00,
        AISD_BUSY = 2'b01
    } aisd_conv_state_t;
endpackage : aisd_pkg

//--- verilog/aisd_top.sv
// Purpose: Sampling interval configuration and shutdown cause status
// Assumes: One core clock; shutdown cause events are pulses on that clock
// Notes:   Interval codes are latched per channel at conversion start
`timescale 1ns/1ns
`default_nettype none
`include "aisd_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module aisd_top
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    input  wire logic [11:0] CONV_START_IN,
    output logic      [11:0] CONV_BUSY_OUT,
    output logic      [11:0] CONV_SAMPLE_OUT,
    input  wire logic        CTRL_PD_EVT_IN,
    input  wire logic        DIG_TSD_EVT_IN,
    input  wire logic        AO_LOSS_EVT_IN,
    input  wire logic        ANALOG_REQ_EVT_IN,
    input  wire logic        REG_SLOW_EVT_IN,
    input  wire logic        ANALOG_TSD_EVT_IN,
    output logic             IRQ_OUT
);

    localparam int NCH = 12;

    logic [7:0]  cell_r;
    logic [31:0] aux_r;
    logic [15:0] test_r;
    logic [7:0]  shdn_r;
    logic [7:0]  irq_stat_r;
    logic [7:0]  irq_mask_r;
    logic [7:0]  shdn_evt;
    logic        wr_cell;
    logic        wr_aux;
    logic        wr_test;
    logic        wr_shdn;
    logic        wr_istat;
    logic        wr_imask;

    aisd_pkg::aisd_code_t ch_code [NCH];

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_cell  = WR_IN && (ADDR_IN == `AISD_OFF_CELL_INTERVAL);
    assign wr_aux   = WR_IN && (ADDR_IN == `AISD_OFF_AUX_INTERVAL);
    assign wr_test  = WR_IN && (ADDR_IN == `AISD_OFF_TEST_INTERVAL);
    assign wr_shdn  = WR_IN && (ADDR_IN == `AISD_OFF_SHDN_STATUS);
    assign wr_istat = WR_IN && (ADDR_IN == `AISD_OFF_IRQ_STATUS);
    assign wr_imask = WR_IN && (ADDR_IN == `AISD_OFF_IRQ_MASK);

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            cell_r <= `AISD_RST_CELL_INTERVAL;
            aux_r  <= `AISD_RST_AUX_INTERVAL;
            test_r <= `AISD_RST_TEST_INTERVAL;
        end
        else
        begin
            if (wr_cell)
            begin
                cell_r <= WDATA_IN[7:0];
            end
            if (wr_aux)
            begin
                aux_r <= WDATA_IN;
            end
            if (wr_test)
            begin
                test_r <= WDATA_IN[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel code mapping
    assign ch_code[0]  = cell_r[7:4];
    assign ch_code[1]  = cell_r[3:0];
    assign ch_code[10] = test_r[15:12];
    assign ch_code[11] = test_r[7:4];

    genvar ga;
    generate
        for (ga = 0; ga < 8; ga++)
        begin : g_aux
            assign ch_code[2 + ga] = aux_r[31 - 4 * ga -: 4];
        end
    endgenerate

    // Supply monitor uses the lowest test nibble; timer channel 11
    aisd_pkg::aisd_code_t vm_code;
    assign vm_code = test_r[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Code to cycles at the core clock rate
    function automatic aisd_pkg::aisd_cycles_t code_cycles(input aisd_pkg::aisd_code_t c);
        // Whole cycles taken from the header; no product that could overflow
        case (c)
            4'h0: code_cycles = `AISD_CYC_CODE_0;
            4'h1: code_cycles = `AISD_CYC_CODE_1;
            4'h2: code_cycles = `AISD_CYC_CODE_2;
            4'h3: code_cycles = `AISD_CYC_CODE_3;
            4'h4: code_cycles = `AISD_CYC_CODE_4;
            4'h5: code_cycles = `AISD_CYC_CODE_5;
            4'h6: code_cycles = `AISD_CYC_CODE_6;
            4'h7: code_cycles = `AISD_CYC_CODE_7;
            4'h8: code_cycles = `AISD_CYC_CODE_8;
            4'h9: code_cycles = `AISD_CYC_CODE_9;
            4'ha: code_cycles = `AISD_CYC_CODE_A;
            4'hb: code_cycles = `AISD_CYC_CODE_B;
            4'hc: code_cycles = `AISD_CYC_CODE_C;
            4'hd: code_cycles = `AISD_CYC_CODE_D;
            4'he: code_cycles = `AISD_CYC_CODE_E;
            default: code_cycles = `AISD_CYC_CODE_F;
        endcase
    endfunction : code_cycles

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel sampling timers; code latched at start
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++)
        begin : g_conv
            aisd_pkg::aisd_conv_state_t state_r;
            aisd_pkg::aisd_cycles_t     cnt_r;
            aisd_pkg::aisd_code_t       code_sel;
            assign code_sel = (gc == 11) ? vm_code : ch_code[gc];
            always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
            begin
                if (RST_IN)
                begin
                    state_r               <= aisd_pkg::AISD_IDLE;
                    cnt_r                 <= '0;
                    CONV_SAMPLE_OUT[gc]   <= 1'b0;
                end
                else
                begin
                    CONV_SAMPLE_OUT[gc] <= 1'b0;
                    case (state_r)
                        aisd_pkg::AISD_IDLE:
                        begin
                            if (CONV_START_IN[gc])
                            begin
                                cnt_r   <= code_cycles(code_sel);
                                state_r <= aisd_pkg::AISD_BUSY;
                            end
                        end
                        aisd_pkg::AISD_BUSY:
                        begin
                            if (cnt_r <= 18'd1)
                            begin
                                CONV_SAMPLE_OUT[gc] <= 1'b1;
                                state_r             <= aisd_pkg::AISD_IDLE;
                            end
                            else
                            begin
                                cnt_r <= cnt_r - 18'd1;
                            end
                        end
                        default: state_r <= aisd_pkg::AISD_IDLE;
                    endcase
                end
            end
            assign CONV_BUSY_OUT[gc] = (state_r == aisd_pkg::AISD_BUSY);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown cause status; set wins over clear
    always_comb
    begin
        shdn_evt                        = 8'h00;
        shdn_evt[`AISD_BIT_CTRL_PD]    = CTRL_PD_EVT_IN;
        shdn_evt[`AISD_BIT_DIG_TSD]    = DIG_TSD_EVT_IN;
        shdn_evt[`AISD_BIT_AO_LOSS]    = AO_LOSS_EVT_IN;
        shdn_evt[`AISD_BIT_ANALOG_REQ] = ANALOG_REQ_EVT_IN;
        shdn_evt[`AISD_BIT_REG_SLOW]   = REG_SLOW_EVT_IN;
        shdn_evt[`AISD_BIT_ANALOG_TSD] = ANALOG_TSD_EVT_IN;
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            shdn_r <= `AISD_RST_SHDN_STATUS;
        end
        else
        begin
            // Write one clears; reserved bits stay zero
            shdn_r <= ((shdn_r & ~(wr_shdn ? WDATA_IN[7:0] : 8'h00)) | shdn_evt)
                      & `AISD_SHDN_RW_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            irq_stat_r <= 8'h00;
            irq_mask_r <= 8'h00;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? WDATA_IN[7:0] : 8'h00)) | shdn_evt;
            if (wr_imask)
            begin
                irq_mask_r <= WDATA_IN[7:0] & `AISD_SHDN_RW_MASK;
            end
        end
    end

    assign IRQ_OUT = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            RDATA_OUT <= 32'h00000000;
        end
        else if (RD_IN)
        begin
            case (ADDR_IN)
                `AISD_OFF_CELL_INTERVAL: RDATA_OUT <= {24'h000000, cell_r};
                `AISD_OFF_AUX_INTERVAL:  RDATA_OUT <= aux_r;
                `AISD_OFF_TEST_INTERVAL: RDATA_OUT <= {16'h0000, test_r};
                `AISD_OFF_SHDN_STATUS:   RDATA_OUT <= {24'h000000, shdn_r};
                `AISD_OFF_IRQ_STATUS:    RDATA_OUT <= {24'h000000, irq_stat_r};
                `AISD_OFF_IRQ_MASK:      RDATA_OUT <= {24'h000000, irq_mask_r};
                default:                 RDATA_OUT <= 32'h00000000;
            endcase
        end
        else
        begin
            RDATA_OUT <= 32'h00000000;
        end
    end

endmodule : aisd_top
`default_nettype wire

//--- tb/aisd_top_props.sv
// Purpose: Port-level checks of aisd_top
// Assumes: One clock, reset active high
// Notes:   Busy length checked on channel 0
`timescale 1ns/1ns
`default_nettype none
`include "aisd_regs.svh"
module aisd_top_props
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    input  wire logic [31:0] RDATA_OUT,
    input  wire logic [11:0] CONV_START_IN,
    input  wire logic [11:0] CONV_BUSY_OUT,
    input  wire logic [11:0] CONV_SAMPLE_OUT,
    input  wire logic        CTRL_PD_EVT_IN,
    input  wire logic        DIG_TSD_EVT_IN,
    input  wire logic        AO_LOSS_EVT_IN,
    input  wire logic        ANALOG_REQ_EVT_IN,
    input  wire logic        REG_SLOW_EVT_IN,
    input  wire logic        ANALOG_TSD_EVT_IN,
    input  wire logic        IRQ_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic        rd_shdn;
    logic [17:0] busy_cnt_r;
    assign rd_shdn = RD_IN && !WR_IN && (ADDR_IN == `AISD_OFF_SHDN_STATUS);
    // Busy cycles seen so far on channel 0
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            busy_cnt_r <= 18'h0;
        else
            busy_cnt_r <= CONV_BUSY_OUT[0] ? busy_cnt_r + 18'h1 : 18'h0;
    end
    AST_CTRL_PD: assert property (CTRL_PD_EVT_IN ##1 rd_shdn |=> RDATA_OUT[7])
        else $error("controller power-down bit missing");
    AST_DIG_TSD: assert property (DIG_TSD_EVT_IN ##1 rd_shdn |=> RDATA_OUT[6])
        else $error("digital thermal bit missing");
    AST_AO_LOSS: assert property (AO_LOSS_EVT_IN ##1 rd_shdn |=> RDATA_OUT[5])
        else $error("supply loss bit missing");
    AST_ANA_REQ: assert property (ANALOG_REQ_EVT_IN ##1 rd_shdn |=> RDATA_OUT[4])
        else $error("analog request bit missing");
    AST_REG_SLOW: assert property (REG_SLOW_EVT_IN ##1 rd_shdn |=> RDATA_OUT[1])
        else $error("regulator slow bit missing");
    AST_ANA_TSD: assert property (ANALOG_TSD_EVT_IN ##1 rd_shdn |=> RDATA_OUT[0])
        else $error("analog thermal bit missing");
    AST_RSVD_ZERO: assert property (rd_shdn |=> RDATA_OUT[3:2] == 2'h0)
        else $error("reserved status bits not zero");
    AST_START_BUSY: assert property (CONV_START_IN[0] && !CONV_BUSY_OUT[0]
        |=> CONV_BUSY_OUT[0] [*8])
        else $error("accepted start did not hold busy");
    AST_SAMPLE_LEN: assert property (CONV_SAMPLE_OUT[0]
        |-> !CONV_BUSY_OUT[0] && busy_cnt_r >= 18'd1032 && busy_cnt_r <= 18'd250000)
        else $error("sampling length out of range");
    AST_SAMPLE_END: assert property (CONV_SAMPLE_OUT[1] && !CONV_START_IN[1]
        |=> !CONV_BUSY_OUT[1])
        else $error("busy held after sample");
    cover property (rd_shdn ##1 RDATA_OUT[4]);
    cover property (CONV_SAMPLE_OUT[11]);
    cover property ($rose(IRQ_OUT));
endmodule : aisd_top_props
bind aisd_top aisd_top_props chk_u (.CORE_CLK_IN, .RST_IN, .ADDR_IN, .WR_IN, .RD_IN,
    .RDATA_OUT, .CONV_START_IN, .CONV_BUSY_OUT, .CONV_SAMPLE_OUT, .CTRL_PD_EVT_IN,
    .DIG_TSD_EVT_IN, .AO_LOSS_EVT_IN, .ANALOG_REQ_EVT_IN, .REG_SLOW_EVT_IN,
    .ANALOG_TSD_EVT_IN, .IRQ_OUT);
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench of aisd_top
// Assumes: 250 MHz core clock
// Notes:   Channel i runs with code i+1 in the first conversion run
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        CORE_CLK_IN = 1'b0;
    logic        RST_IN = 1'b1;
    logic        WR_IN = 1'b0;
    logic        RD_IN = 1'b0;
    logic [7:0]  ADDR_IN = 8'h00;
    logic [31:0] WDATA_IN = 32'h0;
    logic [11:0] CONV_START_IN = 12'h000;
    logic [5:0]  evt = 6'h00;
    logic [31:0] rv;
    wire  [31:0] RDATA_OUT;
    wire  [11:0] CONV_BUSY_OUT;
    wire  [11:0] CONV_SAMPLE_OUT;
    wire         IRQ_OUT;
    wire CTRL_PD_EVT_IN = evt[5], DIG_TSD_EVT_IN = evt[4], AO_LOSS_EVT_IN = evt[3];
    wire ANALOG_REQ_EVT_IN = evt[2], REG_SLOW_EVT_IN = evt[1], ANALOG_TSD_EVT_IN = evt[0];
    int num_errors = 0;
    int compares = 0;
    int bc[12];
    int sc[12];
    localparam int NCYC[16] = '{1032, 1490, 2005, 2500, 3150, 3725, 4350, 4975, 6225, 7500,
        10025, 15000, 25000, 50000, 125000, 250000};
    localparam logic [7:0]  RA[5] = '{8'h3e, 8'h3f, 8'h43, 8'h70, 8'h50};
    localparam logic [31:0] RW[5] = '{32'h12, 32'h3456789a, 32'hb90c, 32'hffffffff, 32'hff};
    localparam logic [31:0] RE[5] = '{32'h12, 32'h3456789a, 32'hb90c, 32'h0, 32'h0};
    localparam logic [7:0]  EB[6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02, 8'h01};
    localparam logic [7:0]  ZA[6] = '{8'h3e, 8'h3f, 8'h43, 8'h50, 8'h60, 8'h61};
    localparam logic [31:0] ZE[6] = '{32'h0, 32'h0, 32'h900, 32'h0, 32'h0, 32'h0};
    aisd_top dut_u (.*);
    initial forever #2 CORE_CLK_IN = ~CORE_CLK_IN;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CORE_CLK_IN);
        WR_IN <= 1'b0;
        @(posedge CORE_CLK_IN);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CORE_CLK_IN);
        RD_IN <= 1'b0;
        #1 rv = RDATA_OUT;
        @(posedge CORE_CLK_IN);
    endtask : rd
    // Start channels, count busy cycles and the sample pulses that follow busy
    task automatic conv(input logic [11:0] m);
        bc = '{default:0};
        sc = '{default:0};
        CONV_START_IN <= m;
        @(posedge CORE_CLK_IN);
        CONV_START_IN <= 12'h000;
        for (int n = 0; n < 26000; n++)
        begin
            #1;
            foreach (bc[i])
            begin
                bc[i] += (CONV_BUSY_OUT[i] === 1'b1);
                sc[i] += (CONV_SAMPLE_OUT[i] === 1'b1);
            end
            if (CONV_BUSY_OUT === 12'h000)
                break;
            @(posedge CORE_CLK_IN);
        end
        if (CONV_BUSY_OUT !== 12'h000)
        begin
            num_errors++;
            $display("[ERR] %0t conversion never ended", $time);
            complete_run();
        end
        @(posedge CORE_CLK_IN);
    endtask : conv
    initial
    begin
        repeat (12) @(posedge CORE_CLK_IN);
        RST_IN <= 1'b0;
        @(posedge CORE_CLK_IN);
        foreach (RA[i])
        begin
            wr(RA[i], RW[i]);
            rd(RA[i]);
            chk(rv, RE[i]);
        end
        $display("register rows done");
        // Late restart and code rewrites while busy
        fork
        begin
            repeat (4) @(posedge CORE_CLK_IN);
            CONV_START_IN <= 12'h001;
            wr(8'h3e, 32'h0);
            CONV_START_IN <= 12'h000;
            wr(8'h3f, 32'h0);
            wr(8'h43, 32'h900);
        end
        join_none
        conv(12'hfff);
        foreach (bc[i])
        begin
            chk(bc[i], NCYC[i + 1]);
            chk(sc[i], 32'h1);
        end
        conv(12'h801);
        chk(bc[0], NCYC[0]);
        chk(bc[11], NCYC[0]);
        $display("conversion test done");
        foreach (EB[k])
        begin
            evt <= 6'h20 >> k;
            @(posedge CORE_CLK_IN);
            evt <= 6'h00;
            rd(8'h50);
            chk(rv, {24'h0, EB[k]});
            wr(8'h50, {24'h0, EB[k]});
            wr(8'h60, {24'h0, EB[k]});
        end
        $display("shutdown cause test done");
        evt <= 6'h06;
        @(posedge CORE_CLK_IN);
        evt <= 6'h00;
        rd(8'h50);
        chk(rv, 32'h12);
        chk({31'h0, IRQ_OUT}, 32'h0);
        wr(8'h61, 32'h12);
        #1 chk({31'h0, IRQ_OUT}, 32'h1);
        wr(8'h60, 32'h12);
        #1 chk({31'h0, IRQ_OUT}, 32'h0);
        $display("interrupt test done");
        CONV_START_IN <= 12'hfff;
        wr(8'h3e, 32'hff);
        CONV_START_IN <= 12'h000;
        RST_IN <= 1'b1;
        repeat (2) @(posedge CORE_CLK_IN);
        RST_IN <= 1'b0;
        @(posedge CORE_CLK_IN);
        chk({20'h0, CONV_BUSY_OUT}, 32'h0);
        foreach (ZA[i])
        begin
            rd(ZA[i]);
            chk(rv, ZE[i]);
        end
        $display("second reset test done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
